//--- design/clock_select_defs.svh
// Offsets, field positions, reset values and timing counts of the clock module
`ifndef CLOCK_SELECT_DEFS_SVH
`define CLOCK_SELECT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MGMT_OFFSET      4'h0
`define CFG_OFFSET       4'h1
`define STATUS_OFFSET    4'h2

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define MGMT_DIV_MSB     3
`define MGMT_DIV_LSB     0
`define MGMT_FORCE_BIT   4
`define MGMT_SUPV_EN_BIT 5
`define MGMT_RESET       8'h10
`define CFG_SEL_HI_BIT   1
`define CFG_SEL_LO_BIT   0
`define CFG_RESET        8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS    20
`define SUPV_MIN_FREQ_KHZ 500
`define SUPV_FAIL_TIME_MS 1
// Longest legal ext period in clk cycles (rounded down)
`define SUPV_GAP_CYC     (1000000 / (`SUPV_MIN_FREQ_KHZ * `CLK_PERIOD_NS))
// Failure time in clk cycles (rounded down)
`define SUPV_FAIL_CYC    (`SUPV_FAIL_TIME_MS * 1000000 / `CLK_PERIOD_NS)

`endif

//--- design/clock_select_pkg.sv
// Types shared by the clock source select module
package clock_select_pkg;

  // Clock sources, in the bit order of the source vector
  typedef enum logic [2:0] {
    SRC_RC1,
    SRC_EXT,
    SRC_RC2,
    SRC_X4,
    SRC_X32
  } src_t;

endpackage

//--- design/clock_source_select_module.sv
// Clock source selection, core divider, sub-clock and external clock supervisor
//
// Behaviour
// - Force bit picks RC1; else select 11 ext, 01 RC2, 10 4 MHz, 00 32 kHz.
// - Core clock and sub-clock; sub-clock is source/16, or 32 kHz in mode 00.
// - Core clock may feed core and peripherals; sub-clock feeds peripherals only.
// - A 4-bit software divider sits in the core clock path.
// - Divider changes never produce a short core clock period; after a source change the low phase may be cut short.
// - With ext selected, reset if it shows no rising edge for 100 clk cycles plus 1 ms.
// - After power-on reset RC1 is the core clock source.
// - Pin A serves as ext clock input or RC2 trimming resistor by mode.
// - Supervisor works only with ext selected; its reset acts as a master reset.
`timescale 1ns/10ps
`include "clock_select_defs.svh"

module clock_source_select_module #(
  parameter int unsigned FAIL_CYC = `SUPV_FAIL_CYC
) (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // Register port
  input  wire logic [3:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [7:0]          rdata_o,
  // Oscillator levels, sampled by clk_i
  input  wire logic                rc1_clk_i,
  input  wire logic                rc2_clk_i,
  input  wire logic                osc_pin_a_i,
  input  wire logic                xtal4_clk_i,
  input  wire logic                xtal32_clk_i,
  // Clock outputs and pin use
  output logic                     core_clock_out_o,
  output logic                     periphery_sub_clock_o,
  output logic                     osc_pin_a_trim_en_o,
  output logic                     osc_pin_a_ext_en_o,
  output clock_select_pkg::src_t   active_src_o,
  // Supervisor reset request
  output logic                     supv_reset_o
);
  import clock_select_pkg::*;

  localparam logic [7:0]  GAP_CYC = 8'(`SUPV_GAP_CYC);
  localparam logic [15:0] FAIL_LIM = 16'(FAIL_CYC);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [3:0]  div_set;
  logic        rc1_force_select;
  logic        supv_en;
  logic        osc_select_hi;
  logic        osc_select_lo;
  logic [3:0]  act_div;
  logic [3:0]  div_cnt;
  logic [3:0]  sub_cnt;
  logic [4:0]  src_prev;
  logic [7:0]  gap_cnt;
  logic [15:0] fail_cnt;

  // Register decode
  wire wr_mgmt = ce_i && wr_i && (addr_i == `MGMT_OFFSET);
  wire wr_cfg  = ce_i && wr_i && (addr_i == `CFG_OFFSET);

  // Software settings; force bit comes up set so RC1 drives after reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_set          <= 4'(`MGMT_RESET >> `MGMT_DIV_LSB);
      rc1_force_select <= 1'b1;
      supv_en          <= 1'b0;
      osc_select_hi    <= 1'b0;
      osc_select_lo    <= 1'b0;
    end
    else if (wr_mgmt)
    begin
      div_set          <= wdata_i[`MGMT_DIV_MSB:`MGMT_DIV_LSB];
      rc1_force_select <= wdata_i[`MGMT_FORCE_BIT];
      supv_en          <= wdata_i[`MGMT_SUPV_EN_BIT];
    end
    else if (wr_cfg)
    begin
      osc_select_hi    <= wdata_i[`CFG_SEL_HI_BIT];
      osc_select_lo    <= wdata_i[`CFG_SEL_LO_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  wire [1:0] osc_sel = {osc_select_hi, osc_select_lo};
  // Source chosen by the mode bits alone; it also feeds the sub-clock divider
  wire src_t mode_src = src_t'((osc_sel == 2'b11) ? SRC_EXT :
                               (osc_sel == 2'b01) ? SRC_RC2 :
                               (osc_sel == 2'b10) ? SRC_X4 : SRC_X32);
  wire src_t req_src  = src_t'(rc1_force_select ? SRC_RC1 : mode_src);
  wire [4:0] src_vec  = {xtal32_clk_i, xtal4_clk_i, rc2_clk_i, osc_pin_a_i, rc1_clk_i};
  wire [4:0] rise_vec = src_vec & ~src_prev;
  wire       act_rise = rise_vec[active_src_o];
  wire       toggle   = act_rise && (div_cnt == act_div);
  wire       change   = (req_src != active_src_o) || (div_set != act_div);
  // A switch lands only where the core clock falls after a full old half-period
  wire       do_switch = ce_i && toggle && core_clock_out_o && change;

  // --------------------------------------------------------------------------
  // Core clock divider
  // --------------------------------------------------------------------------
  // Core clock toggles every (setting+1) rising edges of the active source.
  // The low phase after a switch is counted in new-source edges from zero,
  // so the old high phase stays whole; after a source change the first new-source edge may come at once and cut the low phase short.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      src_prev         <= 5'h00;
      div_cnt          <= 4'h0;
      act_div          <= 4'h0;
      active_src_o     <= SRC_RC1;
      core_clock_out_o <= 1'b0;
    end
    else if (ce_i)
    begin
      src_prev <= src_vec;
      if (do_switch)
      begin
        active_src_o     <= req_src;
        act_div          <= div_set;
        div_cnt          <= 4'h0;
        core_clock_out_o <= 1'b0;
      end
      else if (toggle)
      begin
        div_cnt          <= 4'h0;
        core_clock_out_o <= ~core_clock_out_o;
      end
      else if (act_rise)
        div_cnt <= div_cnt + 4'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Peripheral sub-clock
  // --------------------------------------------------------------------------
  // Sub-clock never reaches the core; it leaves only through its own port
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub_cnt               <= 4'h0;
      periphery_sub_clock_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rise_vec[mode_src])
        sub_cnt <= sub_cnt + 4'h1;
      periphery_sub_clock_o <= (osc_sel == 2'b00) ? xtal32_clk_i : sub_cnt[3];
    end
  end

  // --------------------------------------------------------------------------
  // Pin A use and supervisor
  // --------------------------------------------------------------------------
  wire ext_mon = supv_en && (active_src_o == SRC_EXT);
  wire slow    = (gap_cnt >= GAP_CYC);

  // Gap and failure are timed in clk_i cycles, which the ext clock cannot stall
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gap_cnt             <= 8'h00;
      fail_cnt            <= 16'h0000;
      supv_reset_o        <= 1'b0;
      osc_pin_a_trim_en_o <= 1'b0;
      osc_pin_a_ext_en_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      osc_pin_a_trim_en_o <= (mode_src == SRC_RC2);
      osc_pin_a_ext_en_o  <= (mode_src == SRC_EXT);
      if (!ext_mon || rise_vec[SRC_EXT])
        gap_cnt <= 8'h00;
      else if (!slow)
        gap_cnt <= gap_cnt + 8'h01;
      if (!ext_mon || !slow)
        fail_cnt <= 16'h0000;
      else if (fail_cnt != FAIL_LIM)
        fail_cnt <= fail_cnt + 16'h0001;
      supv_reset_o <= ext_mon && slow && (fail_cnt == FAIL_LIM);
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  wire [7:0] mgmt_val = {2'b00, supv_en, rc1_force_select, div_set};
  wire [7:0] cfg_val  = {6'h00, osc_select_hi, osc_select_lo};
  wire [7:0] st_val   = {2'b00, supv_reset_o, change, 1'b0, active_src_o};
  wire [7:0] rd_mux   = (addr_i == `MGMT_OFFSET)   ? mgmt_val :
                        (addr_i == `CFG_OFFSET)    ? cfg_val :
                        (addr_i == `STATUS_OFFSET) ? st_val : 8'h00;

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (ce_i)
      rdata_o <= rd_i ? rd_mux : 8'h00;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  force_picks_rc1_a: assert property (
    (ce_i && do_switch && rc1_force_select) |=> (active_src_o == SRC_RC1))
    else $error("forced switch did not land on RC1");

  switch_at_fall_a: assert property (
    (ce_i && $changed(active_src_o)) |-> ($past(core_clock_out_o) && !core_clock_out_o))
    else $error("source changed away from a falling core clock edge");

  divider_loaded_a: assert property (
    (ce_i && do_switch) |=> (act_div == $past(div_set) && div_cnt == 4'h0))
    else $error("divider setting not taken at switch");

  core_hold_a: assert property (
    (ce_i && !toggle && !do_switch) |=> $stable(core_clock_out_o))
    else $error("core clock moved without a counted edge");

  sub_mode4_a: assert property (
    (ce_i && osc_sel == 2'b00) |=> (periphery_sub_clock_o == $past(xtal32_clk_i)))
    else $error("sub-clock not following 32 kHz source");

  supv_only_ext_a: assert property (
    (ce_i && !ext_mon) |=> !supv_reset_o)
    else $error("supervisor reset outside ext monitoring");

  supv_needs_slow_a: assert property (
    $rose(supv_reset_o) |-> ($past(fail_cnt) == FAIL_LIM && $past(slow)))
    else $error("supervisor reset before failure time");

  pin_a_exclusive_a: assert property (
    !(osc_pin_a_trim_en_o && osc_pin_a_ext_en_o))
    else $error("pin A used for trim and ext at once");

  read_one_cycle_a: assert property (
    (ce_i && !rd_i) |=> (rdata_o == 8'h00))
    else $error("read data outside its cycle");

endmodule

//--- testbench/osc_sources.sv
// Behavioural oscillators that stand at the clock inputs of the clock module
`timescale 1ns/10ps

module osc_sources (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic ext_run_i,
  // Oscillator levels
  output logic      rc1_o,
  output logic      rc2_o,
  output logic      ext_o,
  output logic      x4_o,
  output logic      x32_o
);
  logic [4:0] free_cnt;
  logic [1:0] ext_cnt;

  // Free-running dividers give half periods of 2, 4, 8 and 16 clk cycles
  initial free_cnt = 5'h00;
  initial ext_cnt  = 2'h0;
  always @(posedge clk_i)
    free_cnt <= free_cnt + 5'h01;

  // External clock halts at its last level while stopped, as a gated crystal does
  always @(posedge clk_i)
    if (ext_run_i)
      ext_cnt <= ext_cnt + 2'h1;

  assign rc1_o = free_cnt[1];
  assign rc2_o = free_cnt[2];
  assign x4_o  = free_cnt[3];
  assign x32_o = free_cnt[4];
  assign ext_o = ext_cnt[1];
endmodule

//--- testbench/clock_source_select_module_tb.sv
// Self-checking testbench of the clock source select module
`timescale 1ns/10ps
`include "clock_select_defs.svh"

module clock_source_select_module_tb;
  import clock_select_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ext_run = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, rv;
  logic rc1, rc2, ext, x4, x32, core, sub, trim_en, ext_en, supv;
  src_t act;
  int mismatches = 0, num_checks = 0, n, i, d;

  always #10 clk_i = ~clk_i;

  osc_sources osc (.clk_i(clk_i), .ext_run_i(ext_run), .rc1_o(rc1), .rc2_o(rc2), .ext_o(ext), .x4_o(x4), .x32_o(x32));
  clock_source_select_module #(.FAIL_CYC(200)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rc1_clk_i(rc1),
    .rc2_clk_i(rc2), .osc_pin_a_i(ext), .xtal4_clk_i(x4), .xtal32_clk_i(x32), .core_clock_out_o(core),
    .periphery_sub_clock_o(sub), .osc_pin_a_trim_en_o(trim_en), .osc_pin_a_ext_en_o(ext_en),
    .active_src_o(act), .supv_reset_o(supv));

  // Expected source and source half period for select bits {hi, lo}
  function automatic src_t exp_src(input logic [1:0] m);
    return (m == 2'b11) ? SRC_EXT : (m == 2'b01) ? SRC_RC2 : (m == 2'b10) ? SRC_X4 : SRC_X32;
  endfunction
  function automatic int exp_h(input logic [1:0] m);
    return (m == 2'b11) ? 2 : (m == 2'b01) ? 4 : (m == 2'b10) ? 8 : 16;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    v = rdata_o;
  endtask

  // Length of a settled high phase of the core clock (sel=0) or sub-clock (sel=1);
  // two falls pass first, so a pending switch has landed before measuring
  task automatic half(input bit sel, output int len);
    len = 0;
    repeat (2)
    begin
      for (int k = 0; k < 3000 && (sel ? sub : core) !== 1'b1; k++) @(posedge clk_i);
      for (int k = 0; k < 3000 && (sel ? sub : core) !== 1'b0; k++) @(posedge clk_i);
    end
    for (int k = 0; k < 3000 && (sel ? sub : core) !== 1'b1; k++) @(posedge clk_i);
    while ((sel ? sub : core) === 1'b1 && len < 3000)
    begin
      @(posedge clk_i);
      len++;
    end
  endtask

  task automatic wait_cond(input int lim, input logic [2:0] s, input bit use_supv, input logic lvl);
    for (int k = 0; k < lim && (use_supv ? supv !== lvl : act !== s); k++) @(posedge clk_i);
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 40000 cycles
  initial
  begin
    #800000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'h34a74cfb));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`MGMT_OFFSET, rv);   chk(rv, `MGMT_RESET);
    rd(`CFG_OFFSET, rv);    chk(rv, `CFG_RESET);
    rd(`STATUS_OFFSET, rv); chk(rv, 8'h00);
    rd(4'h7, rv);           chk(rv, 8'h00);
    // Enable low: the core clock holds and strobes are ignored
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    rv = {7'h00, core};
    wr(`MGMT_OFFSET, 8'h1f);
    repeat (20) @(posedge clk_i);
    chk({7'h00, core}, rv);
    ce_i <= 1'b1;
    rd(`MGMT_OFFSET, rv);   chk(rv, `MGMT_RESET);
    // Divider corners and random settings while RC1 is forced
    for (i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 0 : (i == 1) ? 15 : $urandom % 16;
      wr(`MGMT_OFFSET, 8'h10 | d[7:0]);
      half(1'b0, n); chk(n[7:0], 8'((d + 1) * 2 * 2));
    end
    half(1'b1, n); chk(n[7:0], 8'h10);
    // Every mode with the force bit clear
    for (i = 0; i < 4; i++)
    begin
      wr(`CFG_OFFSET, {6'h00, i[1:0]});
      wr(`MGMT_OFFSET, 8'h20);
      wait_cond(500, exp_src(i[1:0]), 1'b0, 1'b0);
      chk({5'h00, act}, {5'h00, exp_src(i[1:0])});
      chk({6'h00, trim_en, ext_en}, {6'h00, i[1:0] == 2'b01, i[1:0] == 2'b11});
      half(1'b0, n); chk(n[7:0], 8'(2 * exp_h(i[1:0])));
      half(1'b1, n); chk(n[7:0], 8'((i == 0) ? 16 : 16 * exp_h(i[1:0])));
      wr(`MGMT_OFFSET, 8'h30);
      wait_cond(500, SRC_RC1, 1'b0, 1'b0); chk({5'h00, act}, {5'h00, SRC_RC1});
    end
    // External clock dies while selected and supervised
    wr(`MGMT_OFFSET, 8'h20);
    wait_cond(500, SRC_EXT, 1'b0, 1'b0);
    ext_run <= 1'b0;
    repeat (150) @(posedge clk_i);
    chk({7'h00, supv}, 8'h00);
    wait_cond(400, 3'h0, 1'b1, 1'b1); chk({7'h00, supv}, 8'h01);
    rd(`STATUS_OFFSET, rv); chk(rv & 8'h20, 8'h20);
    ext_run <= 1'b1;
    wait_cond(50, 3'h0, 1'b1, 1'b0); chk({7'h00, supv}, 8'h00);
    // Software forces RC1 before stopping the external clock: no reset follows
    wr(`MGMT_OFFSET, 8'h30);
    wait_cond(500, SRC_RC1, 1'b0, 1'b0); chk({5'h00, act}, {5'h00, SRC_RC1});
    ext_run <= 1'b0;
    repeat (500) @(posedge clk_i);
    chk({7'h00, supv}, 8'h00);
    give_verdict();
  end
endmodule
